// File: common/pdc_consts.vh
// Constants for the synthesizer 1 divider configuration register bank
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// Register indexes; byte address on APB is four times the index
`define PDC_IDX_INT_HI 10'h03a
`define PDC_IDX_INT_LO 10'h03b
`define PDC_IDX_NUM_TOP 10'h03c
`define PDC_IDX_NUM_MID 10'h03d
`define PDC_IDX_NUM_BOT 10'h03e
`define PDC_IDX_DEN_TOP 10'h03f
`define PDC_IDX_DEN_MID 10'h040
`define PDC_IDX_DEN_BOT 10'h041
`define PDC_IDX_MOD_CTRL 10'h042
`define PDC_IDX_LOOP_RES 10'h043
`define PDC_IDX_FIRST 10'h03a
`define PDC_IDX_LAST 10'h043
`define PDC_NUM_REGS 10

// Slots in the bank, in index order
`define PDC_SLOT_INT_HI 0
`define PDC_SLOT_INT_LO 1
`define PDC_SLOT_NUM_TOP 2
`define PDC_SLOT_NUM_MID 3
`define PDC_SLOT_NUM_BOT 4
`define PDC_SLOT_DEN_TOP 5
`define PDC_SLOT_DEN_MID 6
`define PDC_SLOT_DEN_BOT 7
`define PDC_SLOT_MOD_CTRL 8
`define PDC_SLOT_LOOP_RES 9

// Writable bit masks; bits outside read as zero
`define PDC_MASK_INT_HI 8'h0f
`define PDC_MASK_FULL 8'hff
`define PDC_MASK_TOP6 8'h3f
`define PDC_MASK_MOD_CTRL 8'h0f
`define PDC_MASK_LOOP_RES 8'h3f

// Reset values
`define PDC_RST_INT_HI 8'h00
`define PDC_RST_INT_LO 8'h66
`define PDC_RST_ZERO 8'h00
`define PDC_RST_MOD_CTRL 8'h0c
`define PDC_RST_LOOP_RES 8'h24
`define PDC_RST_RATIO 12'h066

// Field positions in the modulator control register
`define PDC_DITHER_MSB 3
`define PDC_DITHER_LSB 2
`define PDC_ORDER_MSB 1
`define PDC_ORDER_LSB 0

// Field codes
`define PDC_DITHER_WEAK 2'h0
`define PDC_DITHER_MEDIUM 2'h1
`define PDC_DITHER_STRONG 2'h2
`define PDC_DITHER_OFF 2'h3
`define PDC_ORDER_INT 2'h0
`define PDC_RATIO_MIN 12'h001

`endif

// File: hw/pdc_cfg_byte.v
// One byte-wide configuration register with writable mask and reset value
`timescale 1ns/1ns
module pdc_cfg_byte #(
    parameter [7:0] RST_VAL = 8'h00,
    parameter [7:0] MASK = 8'hff
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Write port
    input wire wr_en,
    input wire [7:0] wdata,
    // Stored value
    output wire [7:0] q
);

    reg [7:0] q_r;

    // Reserved bits never store, so they always read zero
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            q_r <= RST_VAL & MASK;
        else if (wr_en)
            q_r <= wdata & MASK;
    end

    assign q = q_r;

endmodule

// File: hw/pdc_ratio_dec.v
// Decodes the stored divider and modulator fields into registered controls
`timescale 1ns/1ns
`include "pdc_consts.vh"
module pdc_ratio_dec (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Stored fields
    input wire [11:0] int_code,
    input wire [1:0] dither_code,
    input wire [1:0] order_code,
    // Decoded controls
    output reg [11:0] int_ratio_r,
    output reg dither_en_r,
    output reg [2:0] dither_level_r,
    output reg frac_mode_r,
    output reg [2:0] order_onehot_r
);

    // One cycle of latency; a multi-byte value written byte by byte can still be seen half written
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            int_ratio_r <= `PDC_RST_RATIO;
            dither_en_r <= 1'b0;
            dither_level_r <= 3'h0;
            frac_mode_r <= 1'b0;
            order_onehot_r <= 3'h0;
        end
        else
        begin
            // Codes zero and one both divide by one
            int_ratio_r <= (int_code < `PDC_RATIO_MIN) ? `PDC_RATIO_MIN : int_code;
            dither_en_r <= (dither_code != `PDC_DITHER_OFF);
            dither_level_r <= {dither_code == `PDC_DITHER_STRONG,
                               dither_code == `PDC_DITHER_MEDIUM,
                               dither_code == `PDC_DITHER_WEAK};
            frac_mode_r <= (order_code != `PDC_ORDER_INT);
            order_onehot_r <= {order_code == 2'h3, order_code == 2'h2,
                               order_code == 2'h1};
        end
    end

endmodule

// File: hw/pdc_regs.v
// APB register bank holding the synthesizer 1 feedback divider configuration
//
// Behaviour
// - Integer divider is 12 bits from two bytes
// - Upper register bits 3:0 hold bits 11:8
// - Lower byte holds bits 7:0, resets 0x66
// - Codes zero and one divide by one
// - Numerator is 22 bits over three bytes
// - Denominator is 22 bits, same layout
// - Dither select bits 3:2, reset disabled
// - Modulator order bits 1:0, reset integer
// - Loop resistor code bits 5:0, reset 0x24
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`include "pdc_consts.vh"
module pdc_regs (
    // Clock and reset
    input wire clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Raw configuration fields
    output wire [11:0] feedback_int_divider,
    output wire [21:0] frac_numerator,
    output wire [21:0] frac_denominator,
    output wire [1:0] dither_select,
    output wire [1:0] modulator_order,
    output wire [5:0] loop_resistor_code,
    // Decoded controls for the loop
    output wire [11:0] int_ratio,
    output wire dither_enable,
    output wire [2:0] dither_level,
    output wire frac_mode,
    output wire [2:0] order_onehot
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Word map, byte address is four times the index:
    //   0x0e8 integer divider, bits 11:8 in the low nibble
    //   0x0ec integer divider, bits 7:0
    //   0x0f0 numerator, bits 21:16 in the low six bits
    //   0x0f4 numerator, bits 15:8
    //   0x0f8 numerator, bits 7:0
    //   0x0fc denominator, bits 21:16 in the low six bits
    //   0x100 denominator, bits 15:8
    //   0x104 denominator, bits 7:0
    //   0x108 modulator control, dither 3:2 and order 1:0
    //   0x10c loop resistor code in the low six bits
    // Anything else, or a word that is not aligned, is refused

    // Word address hits the bank when aligned and within the index range
    function addr_hit;
        input [11:0] addr;
        reg [9:0] idx;
        begin
            idx = addr[11:2];
            addr_hit = (addr[1:0] == 2'h0) && (idx >= `PDC_IDX_FIRST)
                       && (idx <= `PDC_IDX_LAST);
        end
    endfunction

    // Slot number within the bank; only meaningful on a hit
    function [3:0] addr_slot;
        input [11:0] addr;
        reg [9:0] d;
        begin
            d = addr[11:2] - `PDC_IDX_FIRST;
            addr_slot = d[3:0];
        end
    endfunction

    // Writable mask per slot
    function [7:0] slot_mask;
        input integer s;
        begin
            case (s)
                `PDC_SLOT_INT_HI: slot_mask = `PDC_MASK_INT_HI;
                `PDC_SLOT_NUM_TOP: slot_mask = `PDC_MASK_TOP6;
                `PDC_SLOT_DEN_TOP: slot_mask = `PDC_MASK_TOP6;
                `PDC_SLOT_MOD_CTRL: slot_mask = `PDC_MASK_MOD_CTRL;
                `PDC_SLOT_LOOP_RES: slot_mask = `PDC_MASK_LOOP_RES;
                default: slot_mask = `PDC_MASK_FULL;
            endcase
        end
    endfunction

    // Reset value per slot
    function [7:0] slot_reset;
        input integer s;
        begin
            case (s)
                `PDC_SLOT_INT_HI: slot_reset = `PDC_RST_INT_HI;
                `PDC_SLOT_INT_LO: slot_reset = `PDC_RST_INT_LO;
                `PDC_SLOT_MOD_CTRL: slot_reset = `PDC_RST_MOD_CTRL;
                `PDC_SLOT_LOOP_RES: slot_reset = `PDC_RST_LOOP_RES;
                default: slot_reset = `PDC_RST_ZERO;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB transfer handling

    wire setup_ph;
    wire access_done;
    wire req_hit;
    wire [3:0] req_slot;
    wire wr_fire;
    wire [`PDC_NUM_REGS-1:0] slot_wr;
    wire [8*`PDC_NUM_REGS-1:0] q_flat;
    reg [7:0] rd_byte;

    // Named views of the stored bytes, unpacked below the bank
    wire [7:0] int_hi_q;
    wire [7:0] int_lo_q;
    wire [7:0] num_top_q;
    wire [7:0] num_mid_q;
    wire [7:0] num_bot_q;
    wire [7:0] den_top_q;
    wire [7:0] den_mid_q;
    wire [7:0] den_bot_q;
    wire [7:0] mod_ctrl_q;
    wire [7:0] loop_res_q;

    // Phase of the current transfer
    assign setup_ph = psel & ~penable;
    assign access_done = psel & penable & pready;

    // Address decode, shared by the write enables and the read mux
    assign req_hit = addr_hit(paddr);
    assign req_slot = addr_slot(paddr);

    // Only lane 0 carries a register; upper lanes have nothing to store
    assign wr_fire = access_done & pwrite & req_hit & pstrb[0];

    // Read mux over the stored bytes; misses read zero
    always @*
    begin
        rd_byte = 8'h00;
        if (req_hit)
        begin
            case (req_slot)
                `PDC_SLOT_INT_HI: rd_byte = int_hi_q;
                `PDC_SLOT_INT_LO: rd_byte = int_lo_q;
                `PDC_SLOT_NUM_TOP: rd_byte = num_top_q;
                `PDC_SLOT_NUM_MID: rd_byte = num_mid_q;
                `PDC_SLOT_NUM_BOT: rd_byte = num_bot_q;
                `PDC_SLOT_DEN_TOP: rd_byte = den_top_q;
                `PDC_SLOT_DEN_MID: rd_byte = den_mid_q;
                `PDC_SLOT_DEN_BOT: rd_byte = den_bot_q;
                `PDC_SLOT_MOD_CTRL: rd_byte = mod_ctrl_q;
                `PDC_SLOT_LOOP_RES: rd_byte = loop_res_q;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // Transfer timing, always a single access cycle:
    //   setup edge  - ready, error and data are loaded
    //   access edge - a write lands, the answer drops back to zero

    // Answer is prepared in the setup cycle so every APB output is a flop;
    // this costs nothing since the access phase then ends at its first edge
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            pready <= 1'b0;
        else
            pready <= setup_ph;
    end

    // Error stands with ready for a misaligned or unmapped word
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            pslverr <= 1'b0;
        else
            pslverr <= setup_ph & ~req_hit;
    end

    // Data only for a mapped read; writes and misses return zero
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (setup_ph & ~pwrite & req_hit)
            prdata <= {24'h00_0000, rd_byte};
        else
            prdata <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bank

    genvar i;

    // One write enable per slot, decoded once for the whole bank
    generate
        for (i = 0; i < `PDC_NUM_REGS; i = i + 1)
        begin : g_wr
            assign slot_wr[i] = wr_fire && (req_slot == i);
        end
    endgenerate

    // Each slot is a byte with its own reset value and writable mask
    generate
        for (i = 0; i < `PDC_NUM_REGS; i = i + 1)
        begin : g_byte
            pdc_cfg_byte #(
                .RST_VAL(slot_reset(i)),
                .MASK(slot_mask(i))
            ) u_byte (
                .clk(clk),
                .rst(rst),
                .wr_en(slot_wr[i]),
                .wdata(pwdata[7:0]),
                .q(q_flat[8*i +: 8])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Byte views

    // Unpacked once so the read mux names each register
    assign int_hi_q = q_flat[8*`PDC_SLOT_INT_HI +: 8];
    assign int_lo_q = q_flat[8*`PDC_SLOT_INT_LO +: 8];
    assign num_top_q = q_flat[8*`PDC_SLOT_NUM_TOP +: 8];
    assign num_mid_q = q_flat[8*`PDC_SLOT_NUM_MID +: 8];
    assign num_bot_q = q_flat[8*`PDC_SLOT_NUM_BOT +: 8];
    assign den_top_q = q_flat[8*`PDC_SLOT_DEN_TOP +: 8];
    assign den_mid_q = q_flat[8*`PDC_SLOT_DEN_MID +: 8];
    assign den_bot_q = q_flat[8*`PDC_SLOT_DEN_BOT +: 8];
    assign mod_ctrl_q = q_flat[8*`PDC_SLOT_MOD_CTRL +: 8];
    assign loop_res_q = q_flat[8*`PDC_SLOT_LOOP_RES +: 8];

    ////////////////////////////////////////////////////////////////////////////
    // Field assembly

    // Timing seen by the loop:
    //   raw fields follow the register one edge after the access phase
    //   decoded controls follow one edge later still
    //   multi-byte fields change byte by byte, with no shadow copy

    // Upper nibble over lower byte
    assign feedback_int_divider = {q_flat[8*`PDC_SLOT_INT_HI +: 4],
                                   q_flat[8*`PDC_SLOT_INT_LO +: 8]};

    // Top six bits, then middle, then bottom byte
    assign frac_numerator = {q_flat[8*`PDC_SLOT_NUM_TOP +: 6],
                             q_flat[8*`PDC_SLOT_NUM_MID +: 8],
                             q_flat[8*`PDC_SLOT_NUM_BOT +: 8]};
    assign frac_denominator = {q_flat[8*`PDC_SLOT_DEN_TOP +: 6],
                               q_flat[8*`PDC_SLOT_DEN_MID +: 8],
                               q_flat[8*`PDC_SLOT_DEN_BOT +: 8]};

    // Modulator fields
    assign dither_select = q_flat[8*`PDC_SLOT_MOD_CTRL+`PDC_DITHER_LSB +: 2];
    assign modulator_order = q_flat[8*`PDC_SLOT_MOD_CTRL+`PDC_ORDER_LSB +: 2];

    // Resistor codes beyond the tabulated ones pass through unchanged
    assign loop_resistor_code = q_flat[8*`PDC_SLOT_LOOP_RES +: 6];

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls

    pdc_ratio_dec u_dec (
        .clk(clk),
        .rst(rst),
        .int_code(feedback_int_divider),
        .dither_code(dither_select),
        .order_code(modulator_order),
        .int_ratio_r(int_ratio),
        .dither_en_r(dither_enable),
        .dither_level_r(dither_level),
        .frac_mode_r(frac_mode),
        .order_onehot_r(order_onehot)
    );

endmodule

// File: dv/pdc_regs_monitor.sv
// Port relation checker for the divider register bank
`timescale 1ns/1ns
module pdc_regs_monitor (
    // Clock and reset
    input clk,
    input rst,
    // Bus
    input psel,
    input penable,
    input pwrite,
    input [11:0] paddr,
    input [31:0] pwdata,
    input [3:0] pstrb,
    input [31:0] prdata,
    input pready,
    input pslverr,
    // Fields and decodes
    input [11:0] feedback_int_divider,
    input [1:0] dither_select,
    input [1:0] modulator_order,
    input [11:0] int_ratio,
    input dither_enable,
    input [2:0] dither_level,
    input frac_mode,
    input [2:0] order_onehot
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Committed write; only lane 0 carries a register byte
    wire wr = psel && penable && pwrite && pready && !pslverr && pstrb[0];
    //////////////////////////////
    lo_write_a: assert property (
        wr && paddr == 12'h0ec |=> feedback_int_divider[7:0] == $past(pwdata[7:0]))
        else $error("low byte lost");
    hi_write_a: assert property (
        wr && paddr == 12'h0e8 |=> feedback_int_divider[11:8] == $past(pwdata[3:0]))
        else $error("high bits lost");
    mod_write_a: assert property (
        wr && paddr == 12'h108 |=> {dither_select, modulator_order} == $past(pwdata[3:0]))
        else $error("mode bits lost");
    ratio_map_a: assert property (
        int_ratio == ($past(feedback_int_divider) < 12'h002 ? 12'h001
        : $past(feedback_int_divider))) else $error("bad ratio");
    dither_dec_a: assert property (
        {dither_enable, dither_level} == ($past(dither_select) == 2'h3 ? 4'h0
        : {1'b1, 3'h1 << $past(dither_select)})) else $error("bad dither");
    order_dec_a: assert property (
        {frac_mode, order_onehot} == ($past(modulator_order) == 2'h0 ? 4'h0
        : {1'b1, 3'h1 << ($past(modulator_order) - 2'h1)})) else $error("bad order");
    rd_mod_a: assert property (
        pready && !pwrite && !pslverr && paddr == 12'h108 |->
        prdata == {28'h0, dither_select, modulator_order}) else $error("bad read");
    err_drop_a: assert property (
        pslverr |=> $stable(feedback_int_divider)) else $error("refused write landed");
endmodule
bind pdc_regs pdc_regs_monitor mon (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .feedback_int_divider, .dither_select,
    .modulator_order, .int_ratio, .dither_enable, .dither_level, .frac_mode, .order_onehot);

// File: dv/pdc_regs_tb.sv
// Self-checking bench for the divider register bank
`timescale 1ns/1ns
module pdc_regs_tb;
    // Stimulus, results and counters
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 12'h0, feedback_int_divider, int_ratio;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic [21:0] frac_numerator, frac_denominator;
    logic [1:0] dither_select, modulator_order;
    logic [5:0] loop_resistor_code;
    logic [2:0] dither_level, order_onehot;
    logic dither_enable, frac_mode;
    int n_errors = 0, total_checks = 0;
    pdc_regs dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .feedback_int_divider, .frac_numerator, .frac_denominator,
        .dither_select, .modulator_order, .loop_resistor_code, .int_ratio,
        .dither_enable, .dither_level, .frac_mode, .order_onehot);
    // Free-running 100 MHz clock
    initial forever #5 clk = ~clk;
    //////////////////////////////
    // Compare and count
    task automatic chk(string nm, logic [31:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer; answer taken at the rising edge that sees pready high
    task automatic apb(logic [11:0] a, logic w, logic [31:0] d, logic [3:0] s);
        int n = 0;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        chk("pready", pready, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Fields lag one edge, decodes two
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    // Reset values, then byte layout and reserved bits of every register
    task automatic t_regs;
        logic [7:0] rv [10] = '{8'h0, 8'h66, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0c, 8'h24};
        logic [7:0] mk [10] = '{8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
            8'h0f, 8'h3f};
        logic [11:0] a;
        logic [7:0] b;
        chk("reset ratio", int_ratio, 12'h066);
        for (int i = 0; i < 10; i++)
        begin
            a = 12'h0e8 + 12'(4 * i);
            b = 8'(17 * (i + 1));
            apb(a, 0, 32'h0, 4'h0);
            chk("reset value", rd, rv[i]);
            apb(a, 1, {24'hffffff, b}, 4'hf);
            apb(a, 0, 32'h0, 4'h0);
            chk("readback", rd, b & mk[i]);
            chk("no error", er, 1'b0);
        end
        settle;
        chk("divider", feedback_int_divider, 12'h122);
        chk("numerator", frac_numerator, 22'h334455);
        chk("denominator", frac_denominator, 22'h267788);
        chk("resistor", loop_resistor_code, 6'h2a);
        $display("test regs done");
    endtask
    // Edge codes of the integer divider
    task automatic t_ratio;
        logic [11:0] c [4] = '{12'h000, 12'h001, 12'h002, 12'hfff};
        logic [11:0] x [4] = '{12'h001, 12'h001, 12'h002, 12'hfff};
        for (int j = 0; j < 4; j++)
        begin
            apb(12'h0e8, 1, {28'h0, c[j][11:8]}, 4'h1);
            apb(12'h0ec, 1, {24'h0, c[j][7:0]}, 4'h1);
            settle;
            chk("ratio", int_ratio, x[j]);
        end
        $display("test ratio done");
    endtask
    // Every dither and order code
    task automatic t_modes;
        for (int m = 0; m < 16; m++)
        begin
            apb(12'h108, 1, 32'(m), 4'h1);
            settle;
            chk("dither", {dither_enable, dither_level}, m[3:2] == 2'h3 ? 4'h0
                : {1'b1, 3'h1 << m[3:2]});
            chk("order", {frac_mode, order_onehot}, m[1:0] == 2'h0 ? 4'h0
                : {1'b1, 3'h1 << (m[1:0] - 2'h1)});
            apb(12'h108, 0, 32'h0, 4'h0);
            chk("mode readback", rd, 32'(m));
        end
        $display("test modes done");
    endtask
    // Unmapped and misaligned words, and a write with lane 0 off
    task automatic t_refuse;
        apb(12'h110, 1, 32'h1, 4'h1);
        chk("unmapped error", er, 1'b1);
        apb(12'h0ee, 1, 32'h5a, 4'h1);
        chk("misaligned error", er, 1'b1);
        apb(12'h0ec, 0, 32'h0, 4'h0);
        chk("misaligned dropped", rd, 32'hff);
        apb(12'h10c, 1, 32'h5, 4'h0);
        apb(12'h10c, 0, 32'h0, 4'h0);
        chk("no lane write", rd, 32'h2a);
        $display("test refuse done");
    endtask
    //////////////////////////////
    // Counts, verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 0;
        t_regs;
        t_ratio;
        t_modes;
        t_refuse;
        conclude;
    end
    // Hang guard, several times the expected run
    initial
    begin
        #20000;
        n_errors++;
        conclude;
    end
endmodule
